// ===== smmgd_consts.vh
// Contract
// - grant management memory per enable, open, qualifier
// - closed: code anywhere, data not legacy
// - closed with open illegal; may abort
// - code-line read is code, others data
// - closed only legacy; qualifier only enabled ranges
// - legacy range: management memory, else VGA/south
// - top segment: system memory unless enabled; granted
// - denied high/top segment: writebacks kept, others abort and flag
// - high range disabled goes south for abort
// - granted high range maps onto legacy range
// - VGA port only when exactly one enabled
// - inbound enabled-range hit aborts; flag high/top
// - inbound management accesses skip processor snooping
// - inbound to bridge aborts; DMA is inbound
// - south-origin abort-bound request aborted directly
// - I/O decodes bits 15:3; bit 16 wraps
// - config and VGA I/O decoded before ranges
// - after power-on all I/O to south
// - low bits from byte enables; VGA first
// - ten-bit VGA match, every byte inside
// - full decode matches sixteen bits, every byte
// - config port accesses with enable are config
// - I/O inside enabled base-limit window to port
// - unmatched I/O goes to south link
`ifndef SMMGD_CONSTS_VH
`define SMMGD_CONSTS_VH

// ==================================================
// register offsets
`define SMMGD_OFF_MGMT 8'h00
`define SMMGD_OFF_VGA 8'h04
`define SMMGD_OFF_IOEN 8'h08
`define SMMGD_OFF_TOP_SEGMENT 8'h0C
`define SMMGD_OFF_STAT 8'h10
`define SMMGD_OFF_CFG 8'h14
`define SMMGD_OFF_WIN 8'h20

// ==================================================
// field positions
`define SMMGD_B_GEN 0
`define SMMGD_B_HEN 1
`define SMMGD_B_TEN 2
`define SMMGD_B_LOCK 3
`define SMMGD_B_CLOSED 4
`define SMMGD_B_OPEN 5
`define SMMGD_B_VGAFULL 8
`define SMMGD_B_CFGEN 31
`define SMMGD_B_FLAG 0
`define SMMGD_B_LASTDEST 4

// ==================================================
// reset values
`define SMMGD_RST_MGMT 6'h00
`define SMMGD_RST_PORTS 6'h00
`define SMMGD_RST_TOP_SEGMENT 16'h0000
`define SMMGD_RST_WIN 4'h0

// ==================================================
// destination codes
`define SMMGD_D_SYSMEM 3'h0
`define SMMGD_D_MGMT 3'h1
`define SMMGD_D_SOUTH 3'h2
`define SMMGD_D_PORT 3'h3
`define SMMGD_D_ABORT 3'h4
`define SMMGD_D_CFG 3'h5

// ==================================================
// address ranges
`define SMMGD_LEGACY_TAG 19'h00005
`define SMMGD_HIGH_TAG 19'h07F6D
`define SMMGD_VGA_LO0 16'h03B0
`define SMMGD_VGA_HI0 16'h03BB
`define SMMGD_VGA_LO1 16'h03C0
`define SMMGD_VGA_HI1 16'h03DF
`define SMMGD_CFG_ADDRESS_PORT_QW 13'h019F
`define SMMGD_CFG_DATA_PORT_QW 13'h019F

`endif

// ===== smmgd_io_route.v
`timescale 1ns/1ps
`include "smmgd_consts.vh"

module smmgd_io_route #(
    parameter NPORT = 6
) (
    input wire [16:3] ioAddr,
    input wire [7:0] byteEn,
    input wire inbound,
    input wire cfgEnable,
    input wire [NPORT-1:0] ioEnable,
    input wire [NPORT-1:0] vgaEnable,
    input wire [NPORT-1:0] vgaFull,
    input wire [4*NPORT-1:0] baseFlat,
    input wire [4*NPORT-1:0] limitFlat,
    output reg [2:0] destCode,
    output reg [2:0] destPort,
    output reg [15:0] fwdAddr
);

// ==================================================
// helpers

// vga range match, upper bits dropped unless full decode
function vgaHit;
    input [15:0] a;
    input full;
    reg [15:0] m;
    begin
        m = full ? a : {6'h00, a[9:0]};
        vgaHit = (m >= `SMMGD_VGA_LO0 && m <= `SMMGD_VGA_HI0) ||
                 (m >= `SMMGD_VGA_LO1 && m <= `SMMGD_VGA_HI1);
    end
endfunction

// ==================================================
// decode
reg [2:0] firstByte;
reg [2:0] lastByte;
reg [15:0] startAddr;
reg [15:0] endAddr;
reg matched;
integer p;
integer b;

// ordered routing: vga, config, windows, south
always @*
begin
    firstByte = 3'h0;
    lastByte = 3'h0;
    for (b = 7; b >= 0; b = b - 1)
    begin
        if (byteEn[b])
            firstByte = b[2:0];
    end
    for (b = 0; b < 8; b = b + 1)
    begin
        if (byteEn[b])
            lastByte = b[2:0];
    end
    // bit 16 dropped so the access wraps to the bottom
    startAddr = {ioAddr[15:3], firstByte};
    endAddr = {ioAddr[15:3], lastByte};
    fwdAddr = startAddr;
    destCode = `SMMGD_D_SOUTH;
    destPort = 3'h0;
    matched = 1'b0;
    for (p = 0; p < NPORT; p = p + 1)
    begin
        if (!matched && ioEnable[p] && vgaEnable[p] &&
            vgaHit(startAddr, vgaFull[p]) && vgaHit(endAddr, vgaFull[p]))
        begin
            matched = 1'b1;
            destCode = `SMMGD_D_PORT;
            destPort = p[2:0];
        end
    end
    if (!matched && cfgEnable &&
        ((ioAddr[15:3] == `SMMGD_CFG_ADDRESS_PORT_QW && byteEn == 8'h0F) ||
         (ioAddr[15:3] == `SMMGD_CFG_DATA_PORT_QW && byteEn[3:0] == 4'h0 && byteEn[7:4] != 4'h0)))
    begin
        matched = 1'b1;
        destCode = inbound ? `SMMGD_D_ABORT : `SMMGD_D_CFG;
    end
    for (p = 0; p < NPORT; p = p + 1)
    begin
        if (!matched && ioEnable[p] &&
            startAddr[15:12] >= baseFlat[4*p +: 4] &&
            startAddr[15:12] <= limitFlat[4*p +: 4])
        begin
            matched = 1'b1;
            destCode = `SMMGD_D_PORT;
            destPort = p[2:0];
        end
    end
end

endmodule

// ===== smmgd_top.v
`timescale 1ns/1ps
`include "smmgd_consts.vh"

module smmgd_top #(
    parameter NPORT = 6
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdData_ff,
    input wire reqValid,
    input wire [35:0] reqAddr,
    input wire [7:0] reqByteEn,
    input wire reqIsIo,
    input wire reqCodeRead,
    input wire reqWriteback,
    input wire mgmtQualifierN,
    input wire reqInbound,
    input wire reqFromSouth,
    input wire reqToBridge,
    output reg rspValid_ff,
    output reg [2:0] rspDest_ff,
    output reg [2:0] rspPort_ff,
    output reg [35:0] rspAddr_ff,
    output reg rspNoSnoop_ff,
    output reg mgmtErrFlag_ff
);

// ==================================================
// control registers
reg [5:0] mgmtCtrl_ff;
reg [NPORT-1:0] vgaEnable_ff;
reg [NPORT-1:0] vgaFull_ff;
reg [NPORT-1:0] ioEnable_ff;
reg [15:0] tsegTop_ff;
reg [15:0] tsegSize_ff;
reg cfgEnable_ff;
reg [4*NPORT-1:0] winBase_ff;
reg [4*NPORT-1:0] winLimit_ff;
reg [2:0] lastDest_ff;

wire gEn = mgmtCtrl_ff[`SMMGD_B_GEN];
wire hEn = mgmtCtrl_ff[`SMMGD_B_HEN];
wire tEn = mgmtCtrl_ff[`SMMGD_B_TEN];
wire lock = mgmtCtrl_ff[`SMMGD_B_LOCK];
wire closed = mgmtCtrl_ff[`SMMGD_B_CLOSED];
wire open = mgmtCtrl_ff[`SMMGD_B_OPEN];
wire [2:0] winIdx = regAddr[4:2];
wire winSel = (regAddr[7:5] == 3'h1) && (winIdx < NPORT);

// ==================================================
// helpers

// access grant for one request
function grantAccess;
    input g;
    input lk;
    input cl;
    input op;
    input qual;
    input code;
    input legacy;
    begin
        if (!g)
            grantAccess = 1'b0;
        else if (op && !lk)
            grantAccess = 1'b1;
        else if (!qual)
            grantAccess = 1'b0;
        else if (cl && !code && legacy)
            grantAccess = 1'b0;
        else
            grantAccess = 1'b1;
    end
endfunction

// ==================================================
// range detection
wire [15:0] tsegLow = tsegTop_ff - tsegSize_ff;
wire inLegacy = (reqAddr[35:17] == `SMMGD_LEGACY_TAG);
wire inHigh = (reqAddr[35:17] == `SMMGD_HIGH_TAG);
wire inTseg = (reqAddr[35:20] >= tsegLow) && (reqAddr[35:20] < tsegTop_ff);
wire legacyOn = gEn && !hEn;
wire highOn = gEn && hEn;
wire tsegOn = gEn && tEn;
wire isCode = reqCodeRead;
wire qualified = !mgmtQualifierN;
wire illegal = closed && open;
wire grantLegacy = grantAccess(gEn, lock, closed, open, qualified, isCode, 1'b1);
wire grantOther = grantAccess(gEn, lock, closed, open, qualified, isCode, 1'b0);

// ==================================================
// vga port selection
reg [3:0] vgaCount;
reg [2:0] vgaPort;
integer i;

// count vga-enabled ports and remember one of them
always @*
begin
    vgaCount = 4'h0;
    vgaPort = 3'h0;
    for (i = 0; i < NPORT; i = i + 1)
    begin
        if (vgaEnable_ff[i])
        begin
            vgaCount = vgaCount + 4'h1;
            vgaPort = i[2:0];
        end
    end
end

wire vgaOne = (vgaCount == 4'h1);

// ==================================================
// i/o routing
wire [2:0] ioDest;
wire [2:0] ioPort;
wire [15:0] ioFwd;

smmgd_io_route #(
    .NPORT(NPORT)
) ioRoute (
    .ioAddr(reqAddr[16:3]),
    .byteEn(reqByteEn),
    .inbound(reqInbound),
    .cfgEnable(cfgEnable_ff),
    .ioEnable(ioEnable_ff),
    .vgaEnable(vgaEnable_ff),
    .vgaFull(vgaFull_ff),
    .baseFlat(winBase_ff),
    .limitFlat(winLimit_ff),
    .destCode(ioDest),
    .destPort(ioPort),
    .fwdAddr(ioFwd)
);

// ==================================================
// memory disposition
reg [2:0] nxtDest;
reg [2:0] nxtPort;
reg [35:0] nxtAddr;
reg nxtNoSnoop;
reg errSet;

// route one request from its range, grant and origin
always @*
begin
    nxtDest = `SMMGD_D_SYSMEM;
    nxtPort = 3'h0;
    nxtAddr = reqAddr;
    nxtNoSnoop = 1'b0;
    errSet = 1'b0;
    if (reqIsIo)
    begin
        nxtDest = ioDest;
        nxtPort = ioPort;
        nxtAddr = {20'h00000, ioFwd};
        if (reqInbound && reqToBridge)
        begin
            nxtDest = `SMMGD_D_ABORT;
            nxtPort = 3'h0;
        end
    end
    else if (reqInbound)
    begin
        if (reqToBridge)
            nxtDest = `SMMGD_D_ABORT;
        else if ((inLegacy && legacyOn) || (inHigh && highOn) || (inTseg && tsegOn))
        begin
            nxtDest = `SMMGD_D_ABORT;
            nxtNoSnoop = 1'b1;
            errSet = !(inLegacy && legacyOn);
        end
        else if (inLegacy)
        begin
            nxtDest = vgaOne ? `SMMGD_D_PORT : `SMMGD_D_SOUTH;
            nxtPort = vgaOne ? vgaPort : 3'h0;
        end
        else if (inHigh)
            nxtDest = reqFromSouth ? `SMMGD_D_ABORT : `SMMGD_D_SOUTH;
    end
    else if (inLegacy)
    begin
        if (legacyOn && illegal)
            nxtDest = `SMMGD_D_ABORT;
        else if (legacyOn && grantLegacy)
            nxtDest = `SMMGD_D_MGMT;
        else if (vgaOne)
        begin
            nxtDest = `SMMGD_D_PORT;
            nxtPort = vgaPort;
        end
        else
            nxtDest = `SMMGD_D_SOUTH;
    end
    else if (inTseg)
    begin
        if (!tsegOn)
            nxtDest = `SMMGD_D_SYSMEM;
        else if (illegal)
            nxtDest = `SMMGD_D_ABORT;
        else if (grantOther || reqWriteback)
            nxtDest = `SMMGD_D_MGMT;
        else
        begin
            nxtDest = `SMMGD_D_ABORT;
            errSet = 1'b1;
        end
    end
    else if (inHigh)
    begin
        if (!highOn)
            nxtDest = reqFromSouth ? `SMMGD_D_ABORT : `SMMGD_D_SOUTH;
        else if (illegal)
            nxtDest = `SMMGD_D_ABORT;
        else if (grantOther || reqWriteback)
        begin
            nxtDest = `SMMGD_D_MGMT;
            nxtAddr = {`SMMGD_LEGACY_TAG, reqAddr[16:0]};
        end
        else
        begin
            nxtDest = `SMMGD_D_ABORT;
            errSet = 1'b1;
        end
    end
end

// ==================================================
// response stage

// present the disposition one cycle after the request
always @(posedge sys_clk)
begin
    if (rst)
    begin
        rspValid_ff <= 1'b0;
        rspDest_ff <= `SMMGD_D_SYSMEM;
        rspPort_ff <= 3'h0;
        rspAddr_ff <= 36'h000000000;
        rspNoSnoop_ff <= 1'b0;
        lastDest_ff <= `SMMGD_D_SYSMEM;
    end
    else
    begin
        rspValid_ff <= reqValid;
        if (reqValid)
        begin
            rspDest_ff <= nxtDest;
            rspPort_ff <= nxtPort;
            rspAddr_ff <= nxtAddr;
            rspNoSnoop_ff <= nxtNoSnoop;
            lastDest_ff <= nxtDest;
        end
    end
end

// ==================================================
// register writes

// invalid-access flag: a new event beats a software clear
always @(posedge sys_clk)
begin
    if (rst)
        mgmtErrFlag_ff <= 1'b0;
    else if (reqValid && errSet)
        mgmtErrFlag_ff <= 1'b1;
    else if (regWr && regAddr == `SMMGD_OFF_STAT && regWrData[`SMMGD_B_FLAG])
        mgmtErrFlag_ff <= 1'b0;
end

// configuration registers written by software
always @(posedge sys_clk)
begin
    if (rst)
    begin
        mgmtCtrl_ff <= `SMMGD_RST_MGMT;
        vgaEnable_ff <= `SMMGD_RST_PORTS;
        vgaFull_ff <= `SMMGD_RST_PORTS;
        ioEnable_ff <= `SMMGD_RST_PORTS;
        tsegTop_ff <= `SMMGD_RST_TOP_SEGMENT;
        tsegSize_ff <= `SMMGD_RST_TOP_SEGMENT;
        cfgEnable_ff <= 1'b0;
        winBase_ff <= {NPORT{`SMMGD_RST_WIN}};
        winLimit_ff <= {NPORT{`SMMGD_RST_WIN}};
    end
    else if (regWr)
    begin
        case (regAddr)
            `SMMGD_OFF_MGMT:
                mgmtCtrl_ff <= regWrData[5:0];
            `SMMGD_OFF_VGA:
            begin
                vgaEnable_ff <= regWrData[NPORT-1:0];
                vgaFull_ff <= regWrData[`SMMGD_B_VGAFULL +: NPORT];
            end
            `SMMGD_OFF_IOEN:
                ioEnable_ff <= regWrData[NPORT-1:0];
            `SMMGD_OFF_TOP_SEGMENT:
            begin
                tsegTop_ff <= regWrData[31:16];
                tsegSize_ff <= regWrData[15:0];
            end
            `SMMGD_OFF_CFG:
                cfgEnable_ff <= regWrData[`SMMGD_B_CFGEN];
            default:
            begin
                if (winSel)
                begin
                    winBase_ff[4*winIdx +: 4] <= regWrData[3:0];
                    winLimit_ff[4*winIdx +: 4] <= regWrData[7:4];
                end
            end
        endcase
    end
end

// ==================================================
// register reads

// read data stands one cycle after the strobe, zero otherwise
always @(posedge sys_clk)
begin
    if (rst)
        regRdData_ff <= 32'h00000000;
    else if (!regRd)
        regRdData_ff <= 32'h00000000;
    else
    begin
        case (regAddr)
            `SMMGD_OFF_MGMT:
                regRdData_ff <= {26'h0000000, mgmtCtrl_ff};
            `SMMGD_OFF_VGA:
                regRdData_ff <= {{(24-NPORT){1'b0}}, vgaFull_ff, {(8-NPORT){1'b0}}, vgaEnable_ff};
            `SMMGD_OFF_IOEN:
                regRdData_ff <= {{(32-NPORT){1'b0}}, ioEnable_ff};
            `SMMGD_OFF_TOP_SEGMENT:
                regRdData_ff <= {tsegTop_ff, tsegSize_ff};
            `SMMGD_OFF_STAT:
                regRdData_ff <= {25'h0000000, lastDest_ff, 3'h0, mgmtErrFlag_ff};
            `SMMGD_OFF_CFG:
                regRdData_ff <= {cfgEnable_ff, 31'h00000000};
            default:
            begin
                if (winSel)
                    regRdData_ff <= {24'h000000, winLimit_ff[4*winIdx +: 4], winBase_ff[4*winIdx +: 4]};
                else
                    regRdData_ff <= 32'h00000000;
            end
        endcase
    end
end

endmodule

// ===== smmgd_props.sv
`timescale 1ns/1ps
// ==========
// request path and register port checks
module smmgd_props (
    input logic sys_clk,
    input logic rst,
    input logic [7:0] regAddr,
    input logic [31:0] regWrData,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdData_ff,
    input logic reqValid,
    input logic reqIsIo,
    input logic reqInbound,
    input logic reqToBridge,
    input logic rspValid_ff,
    input logic [2:0] rspDest_ff,
    input logic [2:0] rspPort_ff,
    input logic [35:0] rspAddr_ff,
    input logic rspNoSnoop_ff,
    input logic mgmtErrFlag_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a request taken, then its answer one edge later
    sequence s_req;
        reqValid;
    endsequence
    sequence s_ans;
        ##1 rspValid_ff;
    endsequence
    a_rsp_one_later: assert property (s_req |-> s_ans) else $error("answer missing");
    a_rsp_quiet: assert property (!reqValid |=> !rspValid_ff && $stable(rspDest_ff))
        else $error("answer without request");
    a_bridge_abort: assert property (s_req ##0 (reqInbound && reqToBridge) |=> rspDest_ff == 3'h4)
        else $error("inbound to bridge not aborted");
    a_io_no_bit16: assert property (reqValid && reqIsIo |=> rspAddr_ff[35:16] == 20'h0)
        else $error("io address carries upper bits");
    a_nosnoop_abort: assert property (rspValid_ff && rspNoSnoop_ff |-> rspDest_ff == 3'h4)
        else $error("no-snoop hit not aborted");
    a_flag_cause: assert property ($rose(mgmtErrFlag_ff) |-> rspValid_ff && rspDest_ff == 3'h4)
        else $error("flag set without abort");
    a_flag_sticky: assert property (mgmtErrFlag_ff && !(regWr && regAddr == 8'h10 && regWrData[0])
        |=> mgmtErrFlag_ff) else $error("flag dropped");
    a_port_zero: assert property (rspDest_ff != 3'h3 |-> rspPort_ff == 3'h0)
        else $error("port index off port route");
    a_rdata_idle: assert property (!regRd |=> regRdData_ff == 32'h0) else $error("read data outside slot");
endmodule

// ===== smmgd_fsb_agent.sv
`timescale 1ns/1ps
// ==========
// processor and downstream port request source
module smmgd_fsb_agent (
    input wire sys_clk,
    output reg reqValid,
    output reg [35:0] reqAddr,
    output reg [7:0] reqByteEn,
    output reg reqIsIo,
    output reg reqCodeRead,
    output reg reqWriteback,
    output reg mgmtQualifierN,
    output reg reqInbound,
    output reg reqFromSouth,
    output reg reqToBridge
);
    // idle bus, qualifier not asserted
    initial
    begin
        reqValid = 1'b0;
        reqAddr = 36'h0;
        reqByteEn = 8'h0;
        {reqIsIo, reqCodeRead, reqWriteback, mgmtQualifierN, reqInbound, reqFromSouth, reqToBridge} = 7'h08;
    end
    // one request held over its sampling edge; address scrambled once released
    task send(input [35:0] a, input io, input [7:0] be, input [5:0] f);
    begin
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqAddr <= a;
        reqByteEn <= be;
        reqIsIo <= io;
        {reqCodeRead, reqWriteback, mgmtQualifierN, reqInbound, reqFromSouth, reqToBridge} <= f;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        reqAddr <= ~a;
        reqByteEn <= ~be;
        #1;
    end
    endtask
endmodule

// ===== smm_guard_and_io_route_decode_test.sv
`timescale 1ns/1ps
// ==========
// self-checking bench
module smm_guard_and_io_route_decode_test;
    logic sys_clk, rst, regWr, regRd, reqValid, reqIsIo, reqCodeRead, reqWriteback, mgmtQualifierN;
    logic reqInbound, reqFromSouth, reqToBridge, rspValid_ff, rspNoSnoop_ff, mgmtErrFlag_ff;
    logic [7:0] regAddr, reqByteEn;
    logic [31:0] regWrData, regRdData_ff;
    logic [35:0] reqAddr, rspAddr_ff, a;
    logic [2:0] rspDest_ff, rspPort_ff;
    logic [5:0] m;
    logic [1:0] r;
    logic [3:0] e;
    logic [16:0] off;
    integer failures = 0, num_checks = 0, seed, i, f;
    smmgd_top #(.NPORT(6)) u_smmgd_top (.sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData_ff,
        .reqValid, .reqAddr, .reqByteEn, .reqIsIo, .reqCodeRead, .reqWriteback, .mgmtQualifierN, .reqInbound,
        .reqFromSouth, .reqToBridge, .rspValid_ff, .rspDest_ff, .rspPort_ff, .rspAddr_ff, .rspNoSnoop_ff,
        .mgmtErrFlag_ff);
    smmgd_fsb_agent u_smmgd_fsb_agent (.sys_clk, .reqValid, .reqAddr, .reqByteEn, .reqIsIo, .reqCodeRead,
        .reqWriteback, .mgmtQualifierN, .reqInbound, .reqFromSouth, .reqToBridge);
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ==========
    // helpers
    task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
    begin
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= ad;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    end
    endtask
    task rd(input [7:0] ad, input [31:0] d);
    begin
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdData", regRdData_ff, d);
    end
    endtask
    task tr(input [35:0] ad, input io, input [7:0] be, input [5:0] fl, input [2:0] d, input [2:0] p);
    begin
        u_smmgd_fsb_agent.send(ad, io, be, fl);
        chk("rspValid", rspValid_ff, 1);
        chk("rspDest", rspDest_ff, d);
        chk("rspPort", rspPort_ff, p);
    end
    endtask
    // {flag, dest} for a processor memory request; r 0 legacy, 1 high, 2 top segment
    function [3:0] expMem(input [5:0] mg, input [1:0] rg, input qn, input code, input wb);
        reg en, gr;
        begin
            en = mg[0] && (rg == 0 ? !mg[1] : rg == 1 ? mg[1] : mg[2]);
            gr = (!mg[3] && mg[5]) || (!qn && (rg != 0 || !mg[4] || code));
            if (!en)
                expMem = rg == 2 ? 4'h0 : 4'h2;
            else if (mg[4] && mg[5])
                expMem = 4'h4;
            else if (gr || (rg != 0 && wb))
                expMem = 4'h1;
            else
                expMem = rg == 0 ? 4'h2 : 4'hC;
        end
    endfunction
    task finish_test;
    begin
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        finish_test;
    end
    // ==========
    // main sequence
    initial
    begin
        seed = 32'hB315941F;
        {rst, regWr, regRd, regAddr, regWrData} = {3'b100, 40'h0};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        tr(36'h3B0, 1, 8'h01, 6'h08, 3'h2, 3'h0);
        wr(8'h0C, 32'h00100001);
        rd(8'h0C, 32'h00100001);
        rd(8'h40, 32'h0);
        for (i = 0; i < 80; i++)
        begin
            m = $random(seed);
            r = {$random(seed)} % 3;
            f = $random(seed);
            off = $random(seed);
            a = r == 0 ? 36'hA0000 + off : r == 1 ? 36'hFEDA0000 + off : 36'h00F00000 + off;
            e = expMem(m, r, f[3], f[5], f[4]);
            wr(8'h00, {26'h0, m});
            wr(8'h10, 32'h1);
            tr(a, 0, 8'hFF, {f[5:3], 3'b000}, e[2:0], 3'h0);
            chk("flag", mgmtErrFlag_ff, e[3]);
            if (r == 1 && e[2:0] == 3'h1)
                chk("rspAddr", rspAddr_ff, 36'hA0000 + off);
        end
        wr(8'h00, 32'h3);
        wr(8'h10, 32'h1);
        tr(36'hFEDA0000, 0, 8'hFF, 6'h0C, 3'h4, 3'h0);
        chk("noSnoop", rspNoSnoop_ff, 1);
        chk("flag", mgmtErrFlag_ff, 1);
        rd(8'h10, 32'h41);
        wr(8'h00, 32'h1);
        wr(8'h10, 32'h1);
        tr(36'hA0000, 0, 8'hFF, 6'h0C, 3'h4, 3'h0);
        chk("flag", mgmtErrFlag_ff, 0);
        tr(36'hFEDA0000, 0, 8'hFF, 6'h0E, 3'h4, 3'h0);
        tr(36'h0, 0, 8'hFF, 6'h0D, 3'h4, 3'h0);
        tr(36'h3B0, 1, 8'h01, 6'h0D, 3'h4, 3'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h2);
        tr(36'hA0000, 0, 8'hFF, 6'h08, 3'h3, 3'h1);
        wr(8'h04, 32'h3);
        tr(36'hA0000, 0, 8'hFF, 6'h08, 3'h2, 3'h0);
        wr(8'h08, 32'h2);
        wr(8'h04, 32'h2);
        tr(36'h13B0, 1, 8'h01, 6'h08, 3'h3, 3'h1);
        chk("rspAddr", rspAddr_ff, 36'h13B0);
        tr(36'h13B8, 1, 8'h18, 6'h08, 3'h2, 3'h0);
        wr(8'h04, 32'h202);
        tr(36'h13B0, 1, 8'h01, 6'h08, 3'h2, 3'h0);
        tr(36'h03D8, 1, 8'hFF, 6'h08, 3'h3, 3'h1);
        wr(8'h14, 32'h80000000);
        tr(36'hCF8, 1, 8'h0F, 6'h08, 3'h5, 3'h0);
        tr(36'hCF8, 1, 8'hF0, 6'h08, 3'h5, 3'h0);
        tr(36'hCF8, 1, 8'hF0, 6'h0C, 3'h4, 3'h0);
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h0);
        tr(36'hCF8, 1, 8'h0F, 6'h08, 3'h2, 3'h0);
        wr(8'h2C, 32'h42);
        wr(8'h08, 32'h8);
        tr(36'h4000, 1, 8'h01, 6'h08, 3'h3, 3'h3);
        tr(36'h5000, 1, 8'h01, 6'h08, 3'h2, 3'h0);
        tr(36'h12000, 1, 8'h01, 6'h08, 3'h3, 3'h3);
        chk("rspAddr", rspAddr_ff, 36'h2000);
        finish_test;
    end
endmodule

bind smmgd_top smmgd_props u_smmgd_props (.sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_ff, .reqValid, .reqIsIo, .reqInbound, .reqToBridge, .rspValid_ff, .rspDest_ff,
    .rspPort_ff, .rspAddr_ff, .rspNoSnoop_ff, .mgmtErrFlag_ff);
